/* File: usart_tx_pkg.sv */
// Purpose: shared constants and carriers for the serial mode and transmit block
// Assumes: 8-bit register port, byte-wide data
// Notes:   link side runs on the bit clock from the baud generator
package usart_tx_pkg;

    // register addresses
    localparam logic [7:0] TCS_ADDR  = 8'h98;
    localparam logic [7:0] RCS_ADDR  = 8'h18;
    localparam logic [7:0] TXD_ADDR  = 8'h19;
    localparam logic [7:0] STAT_ADDR = 8'h1A;
    localparam logic [7:0] DIR_ADDR  = 8'h87;

    // transmit_control_status fields
    localparam int unsigned CLOCK_SOURCE_SELECT_BIT = 7;
    localparam int unsigned TX9_BIT  = 6;
    localparam int unsigned TRANSMITTER_ENABLE_BIT = 5;
    localparam int unsigned SYNC_BIT = 4;
    localparam int unsigned HIGH_BAUD_SELECT_BIT = 2;
    localparam int unsigned SHIFT_EMPTY_FLAG_BIT = 1;
    localparam int unsigned NINTH_TRANSMIT_BIT_BIT = 0;
    localparam logic [7:0]  TCS_RESET = 8'h02;
    localparam logic [7:0]  TCS_WMASK = 8'hF5;

    // receive_control_status fields held here
    localparam int unsigned SERIAL_PORT_ENABLE_BIT = 7;
    localparam int unsigned SINGLE_RECEIVE_ENABLE_BIT = 5;
    localparam int unsigned CONTINUOUS_RECEIVE_ENABLE_BIT = 4;
    localparam logic [7:0]  RCS_WMASK = 8'hF0;
    localparam logic [7:0]  RCS_RESET = 8'h00;

    // port_c_direction bits of the two serial pins
    localparam int unsigned DIR_DT_BIT = 7;
    localparam int unsigned DIR_CK_BIT = 6;
    localparam logic [7:0]  DIR_RESET  = 8'hFF;

    // frame lengths in bits
    localparam logic [3:0] ASYNC_BITS_8 = 4'hA;
    localparam logic [3:0] ASYNC_BITS_9 = 4'hB;
    localparam logic [3:0] SYNC_BITS_8  = 4'h8;
    localparam logic [3:0] SYNC_BITS_9  = 4'h9;

    // configuration word passed to the link side
    localparam int unsigned CFG_ACT  = 0;
    localparam int unsigned CFG_SYNC = 1;
    localparam int unsigned CFG_MST  = 2;
    localparam int unsigned CFG_NINE = 3;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } bus_req_t;

    typedef struct packed {
        logic ck;
        logic dt;
    } pin_in_t;

    typedef struct packed {
        logic ck;
        logic ck_oe;
        logic dt;
        logic dt_oe;
    } pin_out_t;

    typedef enum logic [0:0] {
        LS_IDLE  = 1'b0,
        LS_SHIFT = 1'b1
    } link_state_t;

    typedef struct packed {
        logic [7:0] tcs;
        logic [7:0] rcs;
        logic [7:0] dir;
        logic [8:0] txword;
        logic       pending;
        logic       req;
        logic       ack_s1;
        logic       ack_s2;
        logic       busy_s1;
        logic       busy_s2;
        logic [7:0] rdata;
    } sys_st_t;

    typedef struct packed {
        link_state_t state;
        logic [10:0] shreg;
        logic [3:0]  left;
        logic        phase;
        logic        req_s1;
        logic        req_s2;
        logic        ack;
        logic [3:0]  cfg_s1;
        logic [3:0]  cfg_s2;
        logic        ck_s1;
        logic        ck_s2;
        logic        ck_prev;
        logic        ck_out;
        logic        dt_out;
        logic        busy;
    } link_st_t;

endpackage

/* File: usart_mode_and_tx_control.sv */
// Purpose: mode selection and transmit control of a serial port
// Assumes: i_link_clk is the bit clock from the baud generator
// Notes:   receive path and baud generator live outside this block
// Operation
// (RULE1) asynchronous mode is full duplex; transmit never waits on receive
// (RULE2) synchronous mode is half duplex, master or slave clock
// (RULE3) software sets port enable and both pin directions before pins work
// (RULE4) nine-bit frames carry an address or data marker bit
// (RULE5) clock source bit 7: 1 master, 0 slave; ignored asynchronously
// (RULE6) bit 6 selects nine-bit sending; bit 0 is the ninth bit
// (RULE7) control register layout; all zero at reset except shift-empty, one
// (RULE8) receive enables override transmit enable synchronously; shift-empty shows idle
`timescale 1ns/1ns
module usart_mode_and_tx_control (
    // system clock and reset
    input  wire logic                  i_clk,
    input  wire logic                  i_rst,
    // link bit clock
    input  wire logic                  i_link_clk,
    // register port
    input  wire usart_tx_pkg::bus_req_t i_bus,
    output logic [7:0]                 o_rdata,
    // serial pins
    input  wire usart_tx_pkg::pin_in_t  i_pins,
    output usart_tx_pkg::pin_out_t     o_pins,
    // baud generator controls
    output logic                       o_clk_master,
    output logic                       o_high_baud
);
    import usart_tx_pkg::*;

    sys_st_t  s_ff;
    sys_st_t  nxt_s;
    link_st_t l_ff;
    link_st_t nxt_l;

    logic sync_mode;
    logic master;
    logic nine;
    logic pins_ok;
    logic rx_on;
    logic tx_active;
    logic outstanding;
    logic shift_empty;
    logic [3:0] cfg;

    always_comb begin
        sync_mode   = s_ff.tcs[SYNC_BIT];
        master      = sync_mode & s_ff.tcs[CLOCK_SOURCE_SELECT_BIT]; // RULE5
        nine        = s_ff.tcs[TX9_BIT]; // RULE6
        pins_ok     = s_ff.rcs[SERIAL_PORT_ENABLE_BIT] & s_ff.dir[DIR_DT_BIT]
                      & s_ff.dir[DIR_CK_BIT]; // RULE3
        rx_on       = s_ff.rcs[SINGLE_RECEIVE_ENABLE_BIT] | s_ff.rcs[CONTINUOUS_RECEIVE_ENABLE_BIT];
        // async ignores receive enables, so both directions run at once
        tx_active   = pins_ok & s_ff.tcs[TRANSMITTER_ENABLE_BIT]
                      & ~(sync_mode & rx_on); // RULE1 RULE2 RULE8
        outstanding = s_ff.req ^ s_ff.ack_s2;
        shift_empty = ~outstanding & ~s_ff.busy_s2; // RULE8
        cfg         = '0;
        cfg[CFG_ACT]  = tx_active;
        cfg[CFG_SYNC] = sync_mode;
        cfg[CFG_MST]  = master;
        cfg[CFG_NINE] = nine;
    end

    // system side: registers and launch of words
    always_comb begin
        nxt_s = s_ff;
        nxt_s.ack_s1  = l_ff.ack;
        nxt_s.ack_s2  = s_ff.ack_s1;
        nxt_s.busy_s1 = l_ff.busy;
        nxt_s.busy_s2 = s_ff.busy_s1;
        if (i_bus.wr) begin
            unique case (i_bus.addr)
                TCS_ADDR: begin
                    // shift-empty and the unused bit are not writable
                    nxt_s.tcs = (i_bus.wdata & TCS_WMASK)
                                | (s_ff.tcs & ~TCS_WMASK); // RULE7
                end
                RCS_ADDR: begin
                    nxt_s.rcs = i_bus.wdata & RCS_WMASK;
                end
                DIR_ADDR: begin
                    nxt_s.dir = i_bus.wdata;
                end
                TXD_ADDR: begin
                    // word must stay stable while the link side copies it
                    if (!s_ff.pending && !outstanding) begin
                        nxt_s.txword[7:0] = i_bus.wdata;
                        nxt_s.pending     = 1'b1;
                    end
                end
                default: begin
                end
            endcase
        end
        if (s_ff.pending && !outstanding && tx_active) begin
            nxt_s.txword[8] = s_ff.tcs[NINTH_TRANSMIT_BIT_BIT]; // RULE4 RULE6
            nxt_s.req       = ~s_ff.req;
            nxt_s.pending   = 1'b0;
        end
        nxt_s.rdata = 8'h00;
        if (i_bus.rd) begin
            unique case (i_bus.addr)
                TCS_ADDR: begin
                    nxt_s.rdata = s_ff.tcs & TCS_WMASK;
                    nxt_s.rdata[SHIFT_EMPTY_FLAG_BIT] = shift_empty; // RULE7 RULE8
                end
                RCS_ADDR: begin
                    nxt_s.rdata = s_ff.rcs;
                end
                DIR_ADDR: begin
                    nxt_s.rdata = s_ff.dir;
                end
                TXD_ADDR: begin
                    nxt_s.rdata = s_ff.txword[7:0];
                end
                STAT_ADDR: begin
                    nxt_s.rdata[0] = ~s_ff.pending & ~outstanding;
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            s_ff         <= '0;
            s_ff.tcs     <= TCS_RESET; // RULE7
            s_ff.rcs     <= RCS_RESET;
            s_ff.dir     <= DIR_RESET;
        end else begin
            s_ff <= nxt_s;
        end
    end

    // link side: frame shifting on the bit clock
    logic        l_act;
    logic        l_sync;
    logic        l_mst;
    logic        l_nine;
    logic        l_fall;
    logic        l_new;
    logic [10:0] l_word;
    logic [3:0]  l_len;

    always_comb begin
        l_act  = l_ff.cfg_s2[CFG_ACT];
        l_sync = l_ff.cfg_s2[CFG_SYNC];
        l_mst  = l_ff.cfg_s2[CFG_MST];
        l_nine = l_ff.cfg_s2[CFG_NINE];
        l_fall = l_ff.ck_prev & ~l_ff.ck_s2;
        l_new  = l_ff.req_s2 ^ l_ff.ack;
        // ninth bit sits after data; in 8-bit frames it becomes idle level
        if (l_sync) begin
            l_word = {2'b11, (l_nine ? s_ff.txword[8] : 1'b1), s_ff.txword[7:0]};
            l_len  = l_nine ? SYNC_BITS_9 : SYNC_BITS_8; // RULE4
        end else begin
            l_word = {1'b1, (l_nine ? s_ff.txword[8] : 1'b1), s_ff.txword[7:0], 1'b0};
            l_len  = l_nine ? ASYNC_BITS_9 : ASYNC_BITS_8; // RULE4
        end
    end

    always_comb begin
        nxt_l = l_ff;
        nxt_l.req_s1  = s_ff.req;
        nxt_l.req_s2  = l_ff.req_s1;
        nxt_l.cfg_s1  = cfg;
        nxt_l.cfg_s2  = l_ff.cfg_s1;
        nxt_l.ck_s1   = i_pins.ck;
        nxt_l.ck_s2   = l_ff.ck_s1;
        nxt_l.ck_prev = l_ff.ck_s2;
        unique case (l_ff.state)
            LS_IDLE: begin
                nxt_l.phase  = 1'b0;
                // async line marks high, master clock rests low
                nxt_l.ck_out = ~l_sync;
                nxt_l.dt_out = 1'b1;
                if (l_new) begin
                    // acknowledge even when disabled so the sender never hangs
                    nxt_l.ack = ~l_ff.ack;
                    if (l_act) begin
                        nxt_l.state = LS_SHIFT;
                        nxt_l.left  = l_len;
                        if (l_sync && !l_mst) begin
                            // slave: first bit must be ready before the first rise
                            nxt_l.dt_out = l_word[0];
                            nxt_l.shreg  = l_word >> 1;
                        end else begin
                            nxt_l.shreg = l_word;
                        end
                    end
                end
            end
            LS_SHIFT: begin
                if (!l_act) begin
                    nxt_l.state = LS_IDLE;
                end else if (!l_sync) begin
                    nxt_l.ck_out = l_ff.shreg[0]; // RULE1
                    nxt_l.shreg  = l_ff.shreg >> 1;
                    nxt_l.left   = l_ff.left - 4'h1;
                    if (l_ff.left == 4'h1) begin
                        nxt_l.state = LS_IDLE;
                    end
                end else if (l_mst) begin
                    // two bit-clock cycles per bit: data on low, rise on high
                    if (!l_ff.phase) begin
                        nxt_l.ck_out = 1'b0; // RULE2 RULE5
                        nxt_l.dt_out = l_ff.shreg[0];
                        nxt_l.phase  = 1'b1;
                    end else begin
                        nxt_l.ck_out = 1'b1;
                        nxt_l.shreg  = l_ff.shreg >> 1;
                        nxt_l.left   = l_ff.left - 4'h1;
                        nxt_l.phase  = 1'b0;
                        if (l_ff.left == 4'h1) begin
                            nxt_l.state = LS_IDLE;
                        end
                    end
                end else if (l_fall) begin
                    // slave: next bit after each falling edge of the far clock
                    nxt_l.left = l_ff.left - 4'h1; // RULE2 RULE5
                    if (l_ff.left == 4'h1) begin
                        nxt_l.state = LS_IDLE;
                    end else begin
                        nxt_l.dt_out = l_ff.shreg[0];
                        nxt_l.shreg  = l_ff.shreg >> 1;
                    end
                end
            end
        endcase
        nxt_l.busy = (nxt_l.state != LS_IDLE);
    end

    // reset release here is not synchronised to the bit clock; the link
    // sits idle until a request toggles, so a late release is harmless
    always_ff @(posedge i_link_clk or posedge i_rst) begin
        if (i_rst) begin
            l_ff        <= '0;
            l_ff.state  <= LS_IDLE;
            l_ff.ck_out <= 1'b1;
            l_ff.dt_out <= 1'b1;
        end else begin
            l_ff <= nxt_l;
        end
    end

    // pin drivers: async sends on the clock pin; sync sends on the data pin
    always_comb begin
        o_pins.ck    = l_ff.ck_out;
        o_pins.dt    = l_ff.dt_out;
        o_pins.ck_oe = 1'b0;
        o_pins.dt_oe = 1'b0;
        if (pins_ok) begin // RULE3
            if (!sync_mode) begin
                o_pins.ck_oe = s_ff.tcs[TRANSMITTER_ENABLE_BIT]; // RULE1
            end else begin
                o_pins.ck_oe = master; // RULE5
                o_pins.dt_oe = tx_active; // RULE2 RULE8
            end
        end
    end

    assign o_rdata      = s_ff.rdata;
    assign o_clk_master = master;
    assign o_high_baud  = ~sync_mode & s_ff.tcs[HIGH_BAUD_SELECT_BIT]; // RULE8

endmodule

/* File: usart_mode_and_tx_control_checker.sv */
// Purpose: port checks for the serial mode and transmit block
// Assumes: shadow copies follow the register writes seen on the bus
// Notes:   system clock domain only
`timescale 1ns/1ns
module usart_mode_and_tx_control_checker (
    input wire logic                   i_clk,
    input wire logic                   i_rst,
    input wire usart_tx_pkg::bus_req_t i_bus,
    input wire logic [7:0]             o_rdata,
    input wire usart_tx_pkg::pin_out_t o_pins,
    input wire logic                   o_clk_master,
    input wire logic                   o_high_baud
);
    import usart_tx_pkg::*;
    logic [7:0] tcs_ff;
    logic [7:0] rcs_ff;
    logic [7:0] dir_ff;
    logic       pins_on;
    logic       syn;
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            tcs_ff <= 8'h00;
            rcs_ff <= RCS_RESET;
            dir_ff <= DIR_RESET;
        end else if (i_bus.wr) begin
            if (i_bus.addr == TCS_ADDR) tcs_ff <= i_bus.wdata & TCS_WMASK;
            if (i_bus.addr == RCS_ADDR) rcs_ff <= i_bus.wdata & RCS_WMASK;
            if (i_bus.addr == DIR_ADDR) dir_ff <= i_bus.wdata;
        end
    end
    assign pins_on = rcs_ff[SERIAL_PORT_ENABLE_BIT] & dir_ff[DIR_DT_BIT] & dir_ff[DIR_CK_BIT];
    assign syn     = tcs_ff[SYNC_BIT];
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    sequence s_read_tcs;
        i_bus.rd && i_bus.addr == TCS_ADDR;
    endsequence
    a_rdata_idle: assert property (!i_bus.rd |=> o_rdata == 8'h00)
        else $error("read data not zero outside a read");
    a_tcs_layout: assert property (s_read_tcs |=>
        o_rdata[3] == 1'b0 && (o_rdata & TCS_WMASK) == $past(tcs_ff))
        else $error("control register read back wrong");
    a_master_sel: assert property (o_clk_master == (syn & tcs_ff[CLOCK_SOURCE_SELECT_BIT]))
        else $error("clock master output wrong");
    a_high_baud: assert property (o_high_baud == (tcs_ff[HIGH_BAUD_SELECT_BIT] & !syn))
        else $error("high baud output wrong");
    a_pins_off: assert property (!pins_on |-> !o_pins.ck_oe && !o_pins.dt_oe)
        else $error("pins driven while port not set up");
    a_async_rx_in: assert property (!syn |-> !o_pins.dt_oe)
        else $error("receive pin driven in async mode");
    a_async_tx_out: assert property (pins_on && !syn && tcs_ff[TRANSMITTER_ENABLE_BIT] |-> o_pins.ck_oe)
        else $error("transmit pin not driven in async mode");
    a_slave_clk_in: assert property (syn && !tcs_ff[CLOCK_SOURCE_SELECT_BIT] |-> !o_pins.ck_oe)
        else $error("clock pin driven as slave");
    a_sync_rx_wins: assert property (syn && (rcs_ff[SINGLE_RECEIVE_ENABLE_BIT] || rcs_ff[CONTINUOUS_RECEIVE_ENABLE_BIT])
        |-> !o_pins.dt_oe)
        else $error("data pin driven while receiving");
endmodule
bind usart_mode_and_tx_control usart_mode_and_tx_control_checker u_chk (
    .i_clk(i_clk), .i_rst(i_rst), .i_bus(i_bus), .o_rdata(o_rdata),
    .o_pins(o_pins), .o_clk_master(o_clk_master), .o_high_baud(o_high_baud));

/* File: usart_far_end.sv */
// Purpose: terminal on the far side, receives async frames
// Assumes: one bit per link clock, sampled mid bit on the falling edge
// Notes:   sync data is taken on each rising clock while enabled
`timescale 1ns/1ns
module usart_far_end (
    input  wire logic  i_link_clk,
    input  wire logic  i_en,
    input  wire logic  i_nine,
    input  wire logic  i_line,
    input  wire logic  i_sen,
    input  wire logic  i_sck,
    input  wire logic  i_sdt,
    output logic [8:0] o_word,
    output int         o_frames,
    output logic       o_stop,
    output logic [7:0] o_sword,
    output int         o_sbits
);
    logic busy = 1'b0;
    int   cnt;
    initial o_frames = 0;
    always @(negedge i_link_clk) begin
        if (!busy) begin
            if (i_en && i_line === 1'b0) begin
                busy = 1'b1;
                cnt = 0;
                o_word = 9'h000;
            end
        end else if (cnt < (i_nine ? 9 : 8)) begin
            o_word[cnt] = i_line;
            cnt++;
        end else begin
            o_stop = i_line;
            busy = 1'b0;
            o_frames++;
        end
    end
    initial o_sbits = 0;
    // sync side: data taken on each rising clock, LSB first
    always @(posedge i_sck) begin
        if (i_sen) begin
            o_sword = {i_sdt, o_sword[7:1]};
            o_sbits++;
        end
    end
endmodule

/* File: usart_mode_and_tx_control_test.sv */
// Purpose: self-checking bench for the serial mode and transmit block
// Assumes: free running bit clock at 30 ns
// Notes:   released data pin floats high; released clock pin follows ext_ck
`timescale 1ns/1ns
module usart_mode_and_tx_control_test;
    import usart_tx_pkg::*;
    logic       clk;
    logic       lclk;
    logic       rst;
    bus_req_t   bus;
    logic [7:0] rdata;
    pin_in_t    pin_in;
    pin_out_t   pin_out;
    logic       cm;
    logic       hb;
    logic [8:0] word;
    int         frames;
    logic       stop;
    logic [7:0] sword;
    int         sbits;
    logic       sen;
    logic       ext_ck;
    int         num_errors;
    int         checks_done;
    int         seed;
    logic       nine;
    logic       en;
    logic       b;
    logic [7:0] v;
    logic [7:0] t;
    logic [7:0] q;
    usart_mode_and_tx_control u_dut (.i_clk(clk), .i_rst(rst), .i_link_clk(lclk),
        .i_bus(bus), .o_rdata(rdata), .i_pins(pin_in), .o_pins(pin_out),
        .o_clk_master(cm), .o_high_baud(hb));
    usart_far_end u_far (.i_link_clk(lclk), .i_en(en), .i_nine(nine),
        .i_line(pin_in.ck), .i_sen(sen), .i_sck(pin_in.ck), .i_sdt(pin_in.dt),
        .o_word(word), .o_frames(frames), .o_stop(stop), .o_sword(sword), .o_sbits(sbits));
    // a released clock pin follows the far clock
    assign pin_in = '{ck: pin_out.ck_oe ? pin_out.ck : ext_ck,
                      dt: pin_out.dt_oe ? pin_out.dt : 1'b1};
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        lclk = 1'b0;
        #7;
        forever #15 lclk = ~lclk;
    end
    task automatic results();
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input string n, input logic [8:0] e, input logic [8:0] g);
        checks_done++;
        if (g !== e) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    function automatic logic [7:0] exp_tcs(input logic [7:0] w);
        logic [7:0] e;
        e = w & TCS_WMASK;
        e[SHIFT_EMPTY_FLAG_BIT] = 1'b1;
        return e;
    endfunction
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus.wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus.rd <= 1'b0;
        #1 q = rdata;
    endtask
    task automatic wait_empty();
        for (int k = 0; k <= 300; k++) begin
            rd(TCS_ADDR);
            if (q[SHIFT_EMPTY_FLAG_BIT] === 1'b1) break;
            if (k == 300) begin
                chk("idle timeout", 1'b1, 1'b0);
                results();
            end
        end
    endtask
    initial begin
        seed = 98;
        num_errors = 0;
        checks_done = 0;
        bus = '0;
        rst = 1'b1;
        nine = 1'b0;
        en = 1'b0;
        sen = 1'b0;
        ext_ck = 1'b1;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        rd(TCS_ADDR);
        chk("tcs reset", TCS_RESET, q);
        rd(RCS_ADDR);
        chk("rcs reset", RCS_RESET, q);
        rd(DIR_ADDR);
        chk("dir reset", DIR_RESET, q);
        rd(8'h55);
        chk("unmapped", 8'h00, q);
        $display("test reset values done");
        for (int i = 0; i < 10; i++) begin
            v = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : 8'($random(seed));
            wr(TCS_ADDR, v);
            rd(TCS_ADDR);
            chk("tcs", exp_tcs(v), q);
            chk("clk master", v[7] & v[4], cm);
            chk("high baud", v[2] & ~v[4], hb);
        end
        $display("test control register done");
        // drop any sync master setting first: its low idle clock looks like a start bit
        wr(TCS_ADDR, 8'h00);
        wr(RCS_ADDR, 8'h90);
        repeat (10) @(posedge clk);
        for (int n = 0; n < 2; n++) begin
            v = 8'($random(seed));
            b = 1'($random(seed));
            nine = n[0];
            en = 1'b1;
            t = {1'b0, n[0], 6'h20} | {7'h00, b};
            wr(RCS_ADDR, n[0] ? 8'hB0 : 8'h90);
            wr(TCS_ADDR, t);
            wr(TXD_ADDR, v);
            rd(TCS_ADDR);
            chk("shift empty busy", 1'b0, q[SHIFT_EMPTY_FLAG_BIT]);
            rd(STAT_ADDR);
            chk("tx data full", 1'b0, q[0]);
            wr(TXD_ADDR, ~v);
            for (int k = 0; k <= 3000 && frames == n; k++) begin
                @(posedge clk);
                if (k == 3000) begin
                    chk("frame timeout", 1'b1, 1'b0);
                    results();
                end
            end
            chk("frame", {n[0] & b, v}, word);
            chk("stop bit", 1'b1, stop);
            wait_empty();
            rd(TXD_ADDR);
            chk("tx data kept", v, q);
            rd(STAT_ADDR);
            chk("tx data free", 1'b1, q[0]);
        end
        en = 1'b0;
        $display("test async frames done");
        ext_ck <= 1'b0;
        wr(RCS_ADDR, 8'hB0);
        wr(TCS_ADDR, 8'hB0);
        wr(TXD_ADDR, 8'hA5);
        repeat (20) @(posedge clk);
        chk("dt_oe receiving", 1'b0, pin_out.dt_oe);
        sen = 1'b1;
        wr(RCS_ADDR, 8'h80);
        repeat (20) @(posedge clk);
        chk("dt_oe sending", 1'b1, pin_out.dt_oe);
        chk("ck_oe master", 1'b1, pin_out.ck_oe);
        wait_empty();
        chk("master word", 8'hA5, sword);
        chk("master bits", 9'd8, sbits[8:0]);
        v = 8'($random(seed));
        wr(TCS_ADDR, 8'h30);
        wr(TXD_ADDR, v);
        repeat (20) @(posedge clk);
        chk("ck_oe slave", 1'b0, pin_out.ck_oe);
        // far clock slow enough for the two-flop sync and the edge detect
        for (int i = 0; i < 16; i++) begin
            repeat (10) @(posedge clk);
            ext_ck <= ~ext_ck;
        end
        wait_empty();
        sen = 1'b0;
        chk("slave word", v, sword);
        chk("slave bits", 9'd16, sbits[8:0]);
        wr(TCS_ADDR, 8'hB0);
        wr(DIR_ADDR, 8'h7F);
        repeat (2) @(posedge clk);
        chk("ck_oe no dir", 1'b0, pin_out.ck_oe);
        $display("test sync and pins done");
        results();
    end
endmodule
